// [qod_pkg.sv]
// Constants, timing counts and carrier types for the quadrature output block.
// Assumes a single 125 MHz reference clock and a synchronous active-high reset.
package qod_pkg;

  // Clock and sample timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SAMPLE_PERIOD_NS = 100000;
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  // Widths
  localparam int unsigned ANGLE_W = 8;
  localparam int unsigned ACC_W = 16;

  // Speed split and output decoding positions
  localparam logic [7:0] LOW_SPEED_STEPS = 8'h01;
  localparam logic [7:0] INDEX_POS = 8'h00;
  localparam int unsigned PHASE_HI_BIT = 1;
  localparam int unsigned PHASE_LO_BIT = 0;

  // Operating mode, one-hot
  typedef enum logic [1:0] {
    QOD_HOLD = 2'b01,
    QOD_RUN = 2'b10
  } qod_mode_t;

  // Field condition from the analog front end
  typedef struct packed {
    logic outOfRange;
    logic approach;
    logic recede;
  } qod_field_t;

  // Incremental output pins
  typedef struct packed {
    logic quadA;
    logic quadB;
    logic index;
  } qod_incr_t;

  // Whole state of the block
  typedef struct packed {
    qod_mode_t mode;
    logic csSeenLow;
    logic [ACC_W-1:0] sampleCnt;
    logic [ACC_W-1:0] accum;
    logic [ANGLE_W-1:0] rate;
    logic [ANGLE_W-1:0] pos;
    logic [ANGLE_W-1:0] target;
    logic [ANGLE_W-1:0] held;
    qod_incr_t incr;
    logic risingOe;
    logic fallingOe;
  } qod_state_t;

  localparam qod_state_t STATE_RESET = '{
    mode: QOD_HOLD,
    csSeenLow: 1'b0,
    sampleCnt: 16'h0000,
    accum: 16'h0000,
    rate: 8'h00,
    pos: 8'h00,
    target: 8'h00,
    held: 8'h00,
    incr: 3'h7,
    risingOe: 1'b0,
    fallingOe: 1'b0
  };

endpackage

// [qod_quadrature_out.sv]
// Turns sampled magnet angles into A/B/index quadrature and field flags.
// Assumes angle and field inputs synchronous to ref_clk, valid every cycle;
// open-drain pins are resolved outside from the enable outputs.
module qod_quadrature_out #(
  parameter int unsigned SAMPLE_CYCLES = qod_pkg::SAMPLE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [qod_pkg::ANGLE_W-1:0] angleIn,
  input wire logic reverseDirectionBit,
  input wire logic chipSelectN,
  input wire logic offsetDone,
  input wire qod_pkg::qod_field_t fieldStatus,
  output qod_pkg::qod_incr_t incrOut,
  input wire logic fieldRisingFlagNIn,
  output logic fieldRisingFlagNOut,
  output logic fieldRisingFlagNOe,
  input wire logic fieldFallingFlagNIn,
  output logic fieldFallingFlagNOut,
  output logic fieldFallingFlagNOe
);

  qod_pkg::qod_state_t s_q;
  qod_pkg::qod_state_t s_d;
  logic sampleTick;
  logic [qod_pkg::ANGLE_W-1:0] angleEff;
  logic [qod_pkg::ANGLE_W-1:0] diffNow;
  logic [qod_pkg::ANGLE_W-1:0] absNow;
  logic [qod_pkg::ANGLE_W-1:0] diffHeld;
  logic [qod_pkg::ANGLE_W-1:0] absHeld;
  logic [qod_pkg::ANGLE_W-1:0] diffTarget;
  logic [qod_pkg::ACC_W:0] accSum;
  logic lowSpeed;

  // Magnitude of a wrapped two's-complement step count
  function automatic logic [qod_pkg::ANGLE_W-1:0] absSteps(
    input logic [qod_pkg::ANGLE_W-1:0] d
  );
    absSteps = d[qod_pkg::ANGLE_W-1] ? qod_pkg::ANGLE_W'(-d) : d;
  endfunction

  // Quadrature phase decode from a position; only legal in run mode
  function automatic qod_pkg::qod_incr_t decodeIncr(
    input logic [qod_pkg::ANGLE_W-1:0] p
  );
    decodeIncr.quadA = p[qod_pkg::PHASE_HI_BIT] ^ p[qod_pkg::PHASE_LO_BIT];
    decodeIncr.quadB = p[qod_pkg::PHASE_HI_BIT];
    decodeIncr.index = (p == qod_pkg::INDEX_POS);
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    sampleTick = (s_q.sampleCnt == qod_pkg::ACC_W'(SAMPLE_CYCLES - 1));
    s_d.sampleCnt = sampleTick ? '0 : qod_pkg::ACC_W'(s_q.sampleCnt + 1'b1);

    angleEff = reverseDirectionBit ? qod_pkg::ANGLE_W'(-angleIn) : angleIn;

    diffNow = qod_pkg::ANGLE_W'(angleEff - s_q.pos);
    absNow = absSteps(diffNow);
    diffHeld = qod_pkg::ANGLE_W'(s_q.held - s_q.pos);
    absHeld = absSteps(diffHeld);
    diffTarget = qod_pkg::ANGLE_W'(s_q.target - s_q.pos);
    // Speed split on the fresh sample; steps still owed ride in target
    lowSpeed = (absNow <= qod_pkg::LOW_SPEED_STEPS);
    accSum = {1'b0, s_q.accum} + (qod_pkg::ACC_W + 1)'(s_q.rate);

    case (s_q.mode)
      qod_pkg::QOD_HOLD: begin
        // Track silently so the first run step starts from the true angle
        s_d.pos = angleEff;
        s_d.target = angleEff;
        s_d.held = angleEff;
        s_d.accum = '0;
        s_d.rate = '0;
        if (!chipSelectN) begin
          s_d.csSeenLow = 1'b1;
        end
        if ((s_q.csSeenLow || !chipSelectN) && offsetDone) begin
          s_d.mode = qod_pkg::QOD_RUN;
        end
      end
      qod_pkg::QOD_RUN: begin
        if (accSum >= (qod_pkg::ACC_W + 1)'(SAMPLE_CYCLES)) begin
          s_d.accum = qod_pkg::ACC_W'(accSum - (qod_pkg::ACC_W + 1)'(SAMPLE_CYCLES));
          if (diffTarget != '0) begin
            s_d.pos = diffTarget[qod_pkg::ANGLE_W-1] ?
              qod_pkg::ANGLE_W'(s_q.pos - 1'b1) : qod_pkg::ANGLE_W'(s_q.pos + 1'b1);
          end
        end else begin
          s_d.accum = qod_pkg::ACC_W'(accSum);
        end
        if (sampleTick) begin
          // Restart spreading so leftover fractions do not leak between periods
          s_d.accum = '0;
          if (lowSpeed) begin
            s_d.target = angleEff;
            s_d.held = angleEff;
            s_d.rate = absNow;
          end else begin
            s_d.target = s_q.held;
            s_d.held = angleEff;
            s_d.rate = absHeld;
          end
        end
      end
      default: begin
        s_d = qod_pkg::STATE_RESET;
      end
    endcase

    if (s_d.mode == qod_pkg::QOD_RUN) begin
      s_d.incr = decodeIncr(s_d.pos);
    end else begin
      s_d.incr = 3'h7;
    end

    // both flags when out of range
    s_d.risingOe = fieldStatus.outOfRange | fieldStatus.approach;
    s_d.fallingOe = fieldStatus.outOfRange | (fieldStatus.recede & ~fieldStatus.approach);
  end

  // State register; reset restores the power-up all-high state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= qod_pkg::STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Pins straight from state; open drain only ever pulls low
  assign incrOut = s_q.incr;
  assign fieldRisingFlagNOe = s_q.risingOe;
  assign fieldFallingFlagNOe = s_q.fallingOe;
  assign fieldRisingFlagNOut = 1'b0;
  assign fieldFallingFlagNOut = 1'b0;

  // Helper: cycles since the previous sample tick
  logic [qod_pkg::ACC_W-1:0] tickGap;
  logic tickSeen;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tickGap <= '0;
      tickSeen <= 1'b0;
    end else if (sampleTick) begin
      tickGap <= '0;
      tickSeen <= 1'b1;
    end else begin
      tickGap <= qod_pkg::ACC_W'(tickGap + 1'b1);
    end
  end

  // Checks; the reset cycles themselves are excluded by the default disable
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_sample_period;
    sampleTick && tickSeen |-> tickGap == qod_pkg::ACC_W'(SAMPLE_CYCLES - 1);
  endproperty
  a_sample_period: assert property (p_sample_period) else $error("sample period wrong");

  property p_single_step;
    s_q.pos == $past(s_q.pos) || s_q.pos == 8'($past(s_q.pos) + 8'h01) ||
      s_q.pos == 8'($past(s_q.pos) - 8'h01) || $past(s_q.mode) != qod_pkg::QOD_RUN;
  endproperty
  a_single_step: assert property (p_single_step) else $error("position jumped");

  property p_low_speed_target;
    s_q.mode == qod_pkg::QOD_RUN && sampleTick && lowSpeed |=> s_q.target == $past(angleEff);
  endproperty
  a_low_speed_target: assert property (p_low_speed_target) else $error("low speed late");

  property p_high_speed_target;
    s_q.mode == qod_pkg::QOD_RUN && sampleTick && !lowSpeed
      |=> s_q.target == $past(s_q.held) && s_q.held == $past(angleEff);
  endproperty
  a_high_speed_target: assert property (p_high_speed_target) else $error("pipeline wrong");

  property p_phase_decode;
    s_q.mode == qod_pkg::QOD_RUN |-> incrOut.quadA == (s_q.pos[1] ^ s_q.pos[0]) &&
      incrOut.quadB == s_q.pos[1] && incrOut.index == (s_q.pos == qod_pkg::INDEX_POS);
  endproperty
  a_phase_decode: assert property (p_phase_decode) else $error("channel decode wrong");

  property p_quarter_shift;
    $past(s_q.mode) == qod_pkg::QOD_RUN && s_q.mode == qod_pkg::QOD_RUN
      |-> !($changed(incrOut.quadA) && $changed(incrOut.quadB));
  endproperty
  a_quarter_shift: assert property (p_quarter_shift) else $error("A and B moved together");

  property p_index_low;
    s_q.mode == qod_pkg::QOD_RUN && incrOut.index |-> !incrOut.quadA && !incrOut.quadB;
  endproperty
  a_index_low: assert property (p_index_low) else $error("index with A or B high");

  property p_hold_high;
    s_q.mode == qod_pkg::QOD_HOLD |-> incrOut == 3'h7;
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("outputs not high in hold");

  property p_wait_offset;
    !offsetDone && s_q.mode == qod_pkg::QOD_HOLD |=> s_q.mode == qod_pkg::QOD_HOLD;
  endproperty
  a_wait_offset: assert property (p_wait_offset) else $error("left hold early");

  property p_out_of_range;
    fieldStatus.outOfRange |=> fieldRisingFlagNOe && fieldFallingFlagNOe;
  endproperty
  a_out_of_range: assert property (p_out_of_range) else $error("flags not both low");

  property p_axial;
    !fieldStatus.outOfRange && fieldStatus.recede && !fieldStatus.approach
      |=> fieldFallingFlagNOe && !fieldRisingFlagNOe;
  endproperty
  a_axial: assert property (p_axial) else $error("wrong axial flag");

  property p_released;
    fieldStatus == 3'h0 |=> !fieldRisingFlagNOe && !fieldFallingFlagNOe;
  endproperty
  a_released: assert property (p_released) else $error("flag not released");

  property p_reverse;
    s_q.mode == qod_pkg::QOD_HOLD && reverseDirectionBit ##1 s_q.mode == qod_pkg::QOD_HOLD
      |-> s_q.pos == 8'(-$past(angleIn));
  endproperty
  a_reverse: assert property (p_reverse) else $error("direction not reversed");

  property p_a_leads;
    s_q.mode == qod_pkg::QOD_RUN && $past(s_q.mode) == qod_pkg::QOD_RUN &&
      $past(s_q.pos) == 8'h00 && s_q.pos == 8'h01 |-> incrOut.quadA && !incrOut.quadB;
  endproperty
  a_a_leads: assert property (p_a_leads) else $error("A does not lead");

  property p_b_leads;
    s_q.mode == qod_pkg::QOD_RUN && $past(s_q.mode) == qod_pkg::QOD_RUN &&
      $past(s_q.pos) == 8'h00 && s_q.pos == 8'hff |-> incrOut.quadB && !incrOut.quadA;
  endproperty
  a_b_leads: assert property (p_b_leads) else $error("B does not lead");

  property p_no_extra_step;
    $past(s_q.mode) == qod_pkg::QOD_RUN && $past(s_q.pos) == $past(s_q.target)
      |-> s_q.pos == $past(s_q.pos);
  endproperty
  a_no_extra_step: assert property (p_no_extra_step) else $error("step beyond target");

  property p_run_kept;
    s_q.mode == qod_pkg::QOD_RUN |=> s_q.mode == qod_pkg::QOD_RUN;
  endproperty
  a_run_kept: assert property (p_run_kept) else $error("run left without reset");

  property p_leave_hold;
    s_q.mode == qod_pkg::QOD_HOLD && !chipSelectN && offsetDone
      |=> s_q.mode == qod_pkg::QOD_RUN;
  endproperty
  a_leave_hold: assert property (p_leave_hold) else $error("hold not left");

  property p_not_all_high;
    s_q.mode == qod_pkg::QOD_RUN |-> incrOut != 3'h7;
  endproperty
  a_not_all_high: assert property (p_not_all_high) else $error("all high in run");

  property p_approach;
    !fieldStatus.outOfRange && fieldStatus.approach
      |=> fieldRisingFlagNOe && !fieldFallingFlagNOe;
  endproperty
  a_approach: assert property (p_approach) else $error("approach flag wrong");

  // Pins read back through the pull-ups; catches a wrong enable sense
  property p_rising_pin;
    fieldRisingFlagNIn == !fieldRisingFlagNOe;
  endproperty
  a_rising_pin: assert property (p_rising_pin) else $error("rising pin level wrong");

  property p_falling_pin;
    fieldFallingFlagNIn == !fieldFallingFlagNOe;
  endproperty
  a_falling_pin: assert property (p_falling_pin) else $error("falling pin level wrong");

  c_enter_run: cover property ($rose(s_q.mode == qod_pkg::QOD_RUN));
  c_high_speed: cover property (s_q.mode == qod_pkg::QOD_RUN && sampleTick && !lowSpeed);
  c_index_pulse: cover property ($rose(incrOut.index) && s_q.mode == qod_pkg::QOD_RUN);
  c_out_of_range: cover property (fieldRisingFlagNOe && fieldFallingFlagNOe);
  c_reverse_hold: cover property (s_q.mode == qod_pkg::QOD_HOLD && reverseDirectionBit);

endmodule // qod_quadrature_out

// [qod_ctrl_model.sv]
// Receiving controller model: decodes A/B/index into a signed step count.
// Assumes incrOut changes only just after ref_clk edges; all-high means supply loss.
module qod_ctrl_model (
  input wire logic clk,
  input wire logic rst,
  input wire qod_pkg::qod_incr_t incr,
  output logic signed [15:0] stepCnt,
  output logic allHigh,
  output logic jumpErr,
  output logic idxErr
);
  logic [1:0] ph;
  logic [1:0] phPrev;
  logic [7:0] posMod;
  logic [7:0] posNext;

  always_comb begin
    ph = {incr.quadB, incr.quadA ^ incr.quadB};
    posNext = posMod;
    if (ph == phPrev + 2'h1) begin
      posNext = posMod + 8'h01;
    end else if (ph == phPrev - 2'h1) begin
      posNext = posMod - 8'h01;
    end
  end

  assign allHigh = &incr;

  // Count steps; a two-phase jump means a lost pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      phPrev <= 2'h0;
      posMod <= 8'h00;
      stepCnt <= 16'sh0000;
      jumpErr <= 1'b0;
      idxErr <= 1'b0;
    end else if (!allHigh) begin
      phPrev <= ph;
      posMod <= posNext;
      if (posNext == posMod + 8'h01) begin
        stepCnt <= stepCnt + 16'sh0001;
      end else if (posNext != posMod) begin
        stepCnt <= stepCnt - 16'sh0001;
      end
      if (ph == phPrev + 2'h2) begin
        jumpErr <= 1'b1;
      end
      if (incr.index !== (posNext == 8'h00)) begin
        idxErr <= 1'b1;
      end
    end
  end
endmodule // qod_ctrl_model

// [qod_quadrature_out_tb.sv]
// Self-checking bench for qod_quadrature_out with a decoding controller model.
// Assumes SAMPLE_CYCLES shortened to 40; field pins pulled up outside the block.
module qod_quadrature_out_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 40;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] angleIn = 8'h00;
  logic reverseDirectionBit = 1'b0;
  logic chipSelectN = 1'b1;
  logic offsetDone = 1'b0;
  qod_pkg::qod_field_t fieldStatus = '0;
  qod_pkg::qod_incr_t incrOut;
  logic risOut, risOe, falOut, falOe, risPin, falPin;
  logic signed [15:0] stepCnt;
  logic allHigh, jumpErr, idxErr;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;

  // Pull-ups win unless the block enables its driver
  assign risPin = risOe ? risOut : 1'b1;
  assign falPin = falOe ? falOut : 1'b1;

  qod_quadrature_out #(.SAMPLE_CYCLES(SC)) dut (.ref_clk(ref_clk), .rst(rst),
    .angleIn(angleIn), .reverseDirectionBit(reverseDirectionBit),
    .chipSelectN(chipSelectN), .offsetDone(offsetDone), .fieldStatus(fieldStatus),
    .incrOut(incrOut), .fieldRisingFlagNIn(risPin), .fieldRisingFlagNOut(risOut),
    .fieldRisingFlagNOe(risOe), .fieldFallingFlagNIn(falPin),
    .fieldFallingFlagNOut(falOut), .fieldFallingFlagNOe(falOe));

  qod_ctrl_model host (.clk(ref_clk), .rst(rst), .incr(incrOut), .stepCnt(stepCnt),
    .allHigh(allHigh), .jumpErr(jumpErr), .idxErr(idxErr));

  // Clock and hang guard
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // All outputs high until chip select and offset done
  task automatic t_hold();
    @(posedge ref_clk) offsetDone <= 1'b1;
    repeat (20) @(posedge ref_clk);
    #1 check("hold csn high", incrOut, 3'h7);
    @(posedge ref_clk) offsetDone <= 1'b0;
    chipSelectN <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 check("hold offset", incrOut, 3'h7);
    @(posedge ref_clk) offsetDone <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 check("run at zero", incrOut, 3'h1);
  endtask

  // Five field conditions against both flag pins
  task automatic t_field();
    logic [2:0] cond [5] = '{3'h4, 3'h2, 3'h1, 3'h3, 3'h0};
    logic [1:0] pins [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h3};
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk) fieldStatus <= cond[i];
      repeat (2) @(posedge ref_clk);
      #1 check("flag pins", {risPin, falPin}, pins[i]);
    end
  endtask

  // Move the angle and count the pulses the host sees
  task automatic t_move(input logic [7:0] d, input logic signed [15:0] expD, input int bound);
    logic signed [15:0] exp;
    int n;
    exp = stepCnt + expD;
    n = 0;
    @(posedge ref_clk) angleIn <= angleIn + d;
    while (stepCnt !== exp && n < bound) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("in time", n < bound, 1'b1);
    repeat (SC) @(posedge ref_clk);
    #1 check("steps", stepCnt, exp);
    check("jump idx all", {jumpErr, idxErr, allHigh}, 3'h0);
  endtask

  // Flip the direction bit with the angle negated: position must stay put
  task automatic t_reverse();
    logic signed [15:0] cntWas;
    cntWas = stepCnt;
    @(posedge ref_clk) reverseDirectionBit <= 1'b1;
    angleIn <= 8'h00 - angleIn;
    repeat (3 * SC) @(posedge ref_clk);
    #1 check("reverse still", stepCnt, cntWas);
    t_move(8'h04, -16'sd4, 3 * SC + 4);
  endtask

  // Supply restart, chip select tied low: all high until offset done
  task automatic t_restart();
    @(posedge ref_clk) rst <= 1'b1;
    offsetDone <= 1'b0;
    angleIn <= 8'h05;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 check("restart held", incrOut, 3'h7);
    check("supply flag", allHigh, 1'b1);
    @(posedge ref_clk) angleIn <= 8'h00;
    offsetDone <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 check("restart run", incrOut, 3'h1);
    check("restart count", stepCnt, 16'h0000);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_hold();
    t_field();
    t_move(8'h01, 16'sd1, 2 * SC + 4);
    t_move(8'h14, 16'sd20, 3 * SC + 4);
    t_move(8'he2, -16'sd30, 3 * SC + 4);
    t_move(8'h0c, 16'sd12, 3 * SC + 4);
    t_reverse();
    t_restart();
    t_move(8'hfe, 16'sd2, 3 * SC + 4);
    test_done();
  end
endmodule // qod_quadrature_out_tb
